// [rtl/aeh_arm_end.sv]
// arm-side logic: encoder outputs, home detector and limit stopping circuit
`timescale 1ns/10ps
`default_nettype none
module aeh_arm_end (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // link to the controller
    aeh_link_if.dev link,
    // shaft and switch pins, all asynchronous
    input wire logic [aeh_pkg::NUM_AXES-1:0] shaft_step_i,
    input wire logic [aeh_pkg::NUM_AXES-1:0] shaft_ccw_i,
    input wire logic [aeh_pkg::NUM_AXES-1:0] home_beam_cut_i,
    input wire logic [aeh_pkg::NUM_LIM_AXES-1:0] lim_lo_i,
    input wire logic [aeh_pkg::NUM_LIM_AXES-1:0] lim_hi_i,
    // gated motor drive
    output logic [aeh_pkg::NUM_AXES-1:0] motor_pos_o,
    output logic [aeh_pkg::NUM_AXES-1:0] motor_neg_o
);
    import aeh_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 3 * NUM_AXES + 2 * NUM_LIM_AXES;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [NUM_AXES-1:0] step_dly_reg;
    logic [NUM_AXES-1:0] step_s;
    logic [NUM_AXES-1:0] ccw_s;
    logic [NUM_AXES-1:0] beam_s;
    logic [NUM_LIM_AXES-1:0] lo_s;
    logic [NUM_LIM_AXES-1:0] hi_s;

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            step_dly_reg <= '0;
        end
        else
        begin
            sync1_reg <= {lim_hi_i, lim_lo_i, home_beam_cut_i, shaft_ccw_i, shaft_step_i};
            sync2_reg <= sync1_reg;
            step_dly_reg <= step_s;
        end
    end

    assign {hi_s, lo_s, beam_s, ccw_s, step_s} = sync2_reg;

    // ------------------------------------------------------------
    // per-axis encoder and stopping circuit
    // ------------------------------------------------------------
    logic [PHASE_W-1:0] phase_reg [NUM_AXES];
    logic [PHASE_W-1:0] phase_next [NUM_AXES];
    logic [NUM_AXES-1:0] lo_hit;
    logic [NUM_AXES-1:0] hi_hit;
    logic [NUM_AXES-1:0] a_next;
    logic [NUM_AXES-1:0] b_next;
    logic [NUM_AXES-1:0] idx_next;
    logic [NUM_AXES-1:0] mpos_next;
    logic [NUM_AXES-1:0] mneg_next;

    genvar ax;
    generate
        for (ax = 0; ax < NUM_AXES; ax++)
        begin : g_axis
            // the roll axis carries no switches and turns without end
            if (ax < NUM_LIM_AXES)
            begin : g_sw
                assign lo_hit[ax] = lo_s[ax];
                assign hi_hit[ax] = hi_s[ax];
            end
            else
            begin : g_nosw
                assign lo_hit[ax] = 1'b0;
                assign hi_hit[ax] = 1'b0;
            end

            // one step is a quarter slot; 512 slots make one turn
            always_comb
            begin
                phase_next[ax] = phase_reg[ax];
                if (step_s[ax] && !step_dly_reg[ax])
                begin
                    if (ccw_s[ax])
                        phase_next[ax] = (phase_reg[ax] == PHASE_MAX) ? PHASE_ZERO : phase_reg[ax] + PHASE_ONE;
                    else
                        phase_next[ax] = (phase_reg[ax] == PHASE_ZERO) ? PHASE_MAX : phase_reg[ax] - PHASE_ONE;
                end
            end

            // counting up walks AB 00,10,11,01: a leads b for ccw
            assign a_next[ax] = phase_next[ax][1] ^ phase_next[ax][0];
            assign b_next[ax] = phase_next[ax][1];
            // the extra slot lights the index once per turn, one slot wide
            assign idx_next[ax] = (phase_next[ax][PHASE_W-1:2] == PHASE_ZERO[PHASE_W-1:2]);

            // the relay opens only toward the switch; the diode lets reverse drive through
            assign mpos_next[ax] = link.drv_pos[ax] && !link.drv_neg[ax] && !hi_hit[ax];
            assign mneg_next[ax] = link.drv_neg[ax] && !link.drv_pos[ax] && !lo_hit[ax];

            always_ff @(posedge ref_clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                    phase_reg[ax] <= PHASE_ZERO;
                else
                    phase_reg[ax] <= phase_next[ax];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            link.enc_a <= '0;
            link.enc_b <= '0;
            link.enc_idx <= '0;
            link.home_det <= '0;
            link.lim_hit <= '0;
            motor_pos_o <= '0;
            motor_neg_o <= '0;
        end
        else
        begin
            link.enc_a <= a_next;
            link.enc_b <= b_next;
            link.enc_idx <= idx_next;
            link.home_det <= beam_s;
            link.lim_hit <= lo_hit | hi_hit;
            motor_pos_o <= mpos_next;
            motor_neg_o <= mneg_next;
        end
    end

endmodule : aeh_arm_end
`default_nettype wire

// [rtl/aeh_ctl_end.sv]
// motion controller end: quadrature decode, homing sequence, control on/off
`timescale 1ns/10ps
`default_nettype none
module aeh_ctl_end (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // link to the arm
    aeh_link_if.ctl link,
    // operator commands
    input wire logic con_req_i,
    input wire logic control_off_state_req_i,
    input wire logic home_req_i,
    input wire logic [aeh_pkg::NUM_AXES-1:0] jog_pos_i,
    input wire logic [aeh_pkg::NUM_AXES-1:0] jog_neg_i,
    // protection inputs
    input wire logic impact_i,
    input wire logic thermal_i,
    // status
    output logic control_on_o,
    output logic homing_o,
    output logic [aeh_pkg::AXIS_W-1:0] home_axis_o,
    output logic [aeh_pkg::NUM_AXES-1:0] homed_o,
    output logic error_o,
    output logic impact_msg_o,
    output logic [aeh_pkg::NUM_AXES-1:0][aeh_pkg::POS_W-1:0] position_o
);
    import aeh_pkg::*;

    // ------------------------------------------------------------
    // edge history
    // ------------------------------------------------------------
    logic [NUM_AXES-1:0] a_prev_reg;
    logic [NUM_AXES-1:0] b_prev_reg;
    logic [NUM_AXES-1:0] idx_prev_reg;
    logic [NUM_AXES-1:0] lim_prev_reg;

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            a_prev_reg <= '0;
            b_prev_reg <= '0;
            idx_prev_reg <= '0;
            lim_prev_reg <= '0;
        end
        else
        begin
            a_prev_reg <= link.enc_a;
            b_prev_reg <= link.enc_b;
            idx_prev_reg <= link.enc_idx;
            lim_prev_reg <= link.lim_hit;
        end
    end

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    aeh_state_t state_reg;
    aeh_state_t state_next;
    logic [AXIS_W-1:0] axis_reg;
    logic [AXIS_W-1:0] axis_next;
    logic [NUM_AXES-1:0] homed_reg;
    logic [NUM_AXES-1:0] homed_next;
    logic error_reg;
    logic error_next;
    logic msg_reg;
    logic msg_next;
    logic [NUM_AXES-1:0] load_home;
    logic [NUM_AXES-1:0] idx_rise;
    logic fault;

    assign idx_rise = link.enc_idx & ~idx_prev_reg;
    // a newly closed switch faults once; holding it pressed lets recovery proceed
    assign fault = (|(link.lim_hit & ~lim_prev_reg)) || impact_i || thermal_i;

    always_comb
    begin
        state_next = state_reg;
        axis_next = axis_reg;
        homed_next = homed_reg;
        error_next = error_reg;
        msg_next = 1'b0;
        load_home = '0;
        case (state_reg)
            ST_CONTROL_OFF:
            begin
                // drive comes back only through an explicit control-on request
                if (con_req_i && !fault)
                begin
                    state_next = ST_CONTROL_ON;
                    error_next = 1'b0;
                end
            end
            ST_CONTROL_ON:
            begin
                if (home_req_i)
                begin
                    state_next = ST_HOME_SEEK;
                    axis_next = FIRST_AXIS;
                    homed_next = '0;
                end
            end
            ST_HOME_SEEK:
            begin
                if (link.home_det[axis_reg])
                    state_next = ST_HOME_INDEX;
            end
            ST_HOME_INDEX:
            begin
                if (idx_rise[axis_reg])
                begin
                    load_home[axis_reg] = 1'b1;
                    homed_next[axis_reg] = 1'b1;
                    if (axis_reg == LAST_AXIS)
                        state_next = ST_CONTROL_ON;
                    else
                    begin
                        axis_next = axis_reg + 3'h1;
                        state_next = ST_HOME_SEEK;
                    end
                end
            end
            default:
            begin
                state_next = ST_CONTROL_OFF;
            end
        endcase
        // protection and the operator's off request win over any step
        if (fault)
        begin
            state_next = ST_CONTROL_OFF;
            error_next = 1'b1;
            msg_next = 1'b1;
            load_home = '0;
        end
        else if (control_off_state_req_i)
        begin
            state_next = ST_CONTROL_OFF;
            load_home = '0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_reg <= ST_CONTROL_OFF;
            axis_reg <= FIRST_AXIS;
            homed_reg <= '0;
            error_reg <= 1'b0;
            msg_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            axis_reg <= axis_next;
            homed_reg <= homed_next;
            error_reg <= error_next;
            msg_reg <= msg_next;
        end
    end

    // ------------------------------------------------------------
    // per-axis decode, position and drive
    // ------------------------------------------------------------
    logic signed [POS_W-1:0] pos_reg [NUM_AXES];
    logic signed [POS_W-1:0] pos_next [NUM_AXES];
    logic [NUM_AXES-1:0] dpos_next;
    logic [NUM_AXES-1:0] dneg_next;
    logic [NUM_AXES-1:0] dpos_reg;
    logic [NUM_AXES-1:0] dneg_reg;

    genvar ax;
    generate
        for (ax = 0; ax < NUM_AXES; ax++)
        begin : g_axis
            logic [1:0] ph_old;
            logic [1:0] ph_new;
            logic [1:0] step;
            logic soft_pos_ok;
            logic soft_neg_ok;

            // gray AB to a two-bit phase, so one legal edge is plus or minus one
            assign ph_old = {b_prev_reg[ax], a_prev_reg[ax] ^ b_prev_reg[ax]};
            assign ph_new = {link.enc_b[ax], link.enc_a[ax] ^ link.enc_b[ax]};
            assign step = ph_new - ph_old;

            always_comb
            begin
                pos_next[ax] = pos_reg[ax];
                if (load_home[ax])
                    pos_next[ax] = HOME_REF;
                else if (step == QSTEP_UP)
                    pos_next[ax] = pos_reg[ax] + POS_ONE;
                else if (step == QSTEP_DOWN)
                    pos_next[ax] = pos_reg[ax] - POS_ONE;
                // a jump of two phases is illegal and leaves the count alone
            end

            // only the roll axis needs a soft window; it has no switches to lean on
            if (ax == ROLL_AXIS)
            begin : g_soft
                assign soft_pos_ok = !homed_reg[ax] || (pos_reg[ax] < ROLL_POS_MAX);
                assign soft_neg_ok = !homed_reg[ax] || (pos_reg[ax] > ROLL_POS_MIN);
            end
            else
            begin : g_nosoft
                assign soft_pos_ok = 1'b1;
                assign soft_neg_ok = 1'b1;
            end

            always_comb
            begin
                dpos_next[ax] = 1'b0;
                dneg_next[ax] = 1'b0;
                case (state_next)
                    ST_CONTROL_ON:
                    begin
                        dpos_next[ax] = jog_pos_i[ax] && !jog_neg_i[ax] && soft_pos_ok;
                        dneg_next[ax] = jog_neg_i[ax] && !jog_pos_i[ax] && soft_neg_ok;
                    end
                    ST_HOME_SEEK, ST_HOME_INDEX:
                    begin
                        dpos_next[ax] = (axis_next == AXIS_W'(ax));
                    end
                    default:
                    begin
                        dpos_next[ax] = 1'b0;
                    end
                endcase
            end

            always_ff @(posedge ref_clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                    pos_reg[ax] <= POS_RESET;
                else
                    pos_reg[ax] <= pos_next[ax];
            end

            assign position_o[ax] = pos_reg[ax];
        end
    endgenerate

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            dpos_reg <= '0;
            dneg_reg <= '0;
        end
        else
        begin
            dpos_reg <= dpos_next;
            dneg_reg <= dneg_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.drv_pos = dpos_reg;
    assign link.drv_neg = dneg_reg;
    assign control_on_o = (state_reg != ST_CONTROL_OFF);
    assign homing_o = (state_reg == ST_HOME_SEEK) || (state_reg == ST_HOME_INDEX);
    assign home_axis_o = axis_reg;
    assign homed_o = homed_reg;
    assign error_o = error_reg;
    assign impact_msg_o = msg_reg;

endmodule : aeh_ctl_end
`default_nettype wire

// [rtl/aeh_link_if.sv]
// link between the arm-side logic and the motion controller
`timescale 1ns/10ps
`default_nettype none
interface aeh_link_if;
    import aeh_pkg::*;

    // encoder and switch signals toward the controller
    logic [NUM_AXES-1:0] enc_a;
    logic [NUM_AXES-1:0] enc_b;
    logic [NUM_AXES-1:0] enc_idx;
    logic [NUM_AXES-1:0] home_det;
    logic [NUM_AXES-1:0] lim_hit;
    // motor drive requests toward the arm
    logic [NUM_AXES-1:0] drv_pos;
    logic [NUM_AXES-1:0] drv_neg;

    modport dev (
        output enc_a,
        output enc_b,
        output enc_idx,
        output home_det,
        output lim_hit,
        input drv_pos,
        input drv_neg
    );

    modport ctl (
        input enc_a,
        input enc_b,
        input enc_idx,
        input home_det,
        input lim_hit,
        output drv_pos,
        output drv_neg
    );

endinterface : aeh_link_if
`default_nettype wire

// [rtl/aeh_pkg.sv]
// shared constants and types for the axis encoder, homing and limit ends
package aeh_pkg;

    // ------------------------------------------------------------
    // axis layout
    // ------------------------------------------------------------
    localparam int NUM_AXES = 5;
    localparam int NUM_LIM_AXES = 4;
    localparam int ROLL_AXIS = 4;
    localparam int AXIS_W = 3;
    localparam logic [AXIS_W-1:0] FIRST_AXIS = 3'h0;
    localparam logic [AXIS_W-1:0] LAST_AXIS = 3'h4;

    // ------------------------------------------------------------
    // encoder geometry
    // ------------------------------------------------------------
    localparam int SLOTS_PER_REV = 512;
    localparam int COUNTS_PER_SLOT = 4;
    localparam int PHASE_W = 11;
    localparam logic [PHASE_W-1:0] PHASE_MAX = PHASE_W'(SLOTS_PER_REV * COUNTS_PER_SLOT - 1);
    localparam logic [PHASE_W-1:0] PHASE_ZERO = 11'h000;
    localparam logic [PHASE_W-1:0] PHASE_ONE = 11'h001;
    // quadrature phase steps as seen by the decoder
    localparam logic [1:0] QSTEP_NONE = 2'h0;
    localparam logic [1:0] QSTEP_UP = 2'h1;
    localparam logic [1:0] QSTEP_DOWN = 2'h3;

    // ------------------------------------------------------------
    // position counter
    // ------------------------------------------------------------
    localparam int POS_W = 24;
    localparam logic signed [POS_W-1:0] POS_ONE = 24'sh000001;
    localparam logic signed [POS_W-1:0] POS_RESET = 24'sh000000;
    localparam logic signed [POS_W-1:0] HOME_REF = 24'sh000000;
    // soft travel window for the endless roll axis, in quadrature counts
    localparam logic signed [POS_W-1:0] ROLL_POS_MAX = 24'sh00c800;
    localparam logic signed [POS_W-1:0] ROLL_POS_MIN = -24'sh00c800;

    // ------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_CONTROL_OFF,
        ST_CONTROL_ON,
        ST_HOME_SEEK,
        ST_HOME_INDEX
    } aeh_state_t;

endpackage : aeh_pkg

// [test/aeh_link_monitor.sv]
// concurrent checks on the link between the arm end and the controller end
`timescale 1ns/10ps
`default_nettype none
module aeh_link_monitor (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // link signals
    input wire logic [aeh_pkg::NUM_AXES-1:0] enc_a,
    input wire logic [aeh_pkg::NUM_AXES-1:0] enc_b,
    input wire logic [aeh_pkg::NUM_AXES-1:0] enc_idx,
    input wire logic [aeh_pkg::NUM_AXES-1:0] home_det,
    input wire logic [aeh_pkg::NUM_AXES-1:0] lim_hit,
    input wire logic [aeh_pkg::NUM_AXES-1:0] drv_pos,
    input wire logic [aeh_pkg::NUM_AXES-1:0] drv_neg
);
    import aeh_pkg::*;

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_ab_one_change:
        assert property (((enc_a ^ $past(enc_a)) & (enc_b ^ $past(enc_b))) == '0)
        else $error("quadrature pair changed both lines at once");
    a_idx_slot_edge:
        assert property (((enc_idx ^ $past(enc_idx)) & enc_a) == '0)
        else $error("index moved outside the slot boundary");
    // the index settles one edge after release with the pair still idle
    a_idx_moves_with_ab:
        assert property ($past(rstn_i, 2) |-> ((enc_idx ^ $past(enc_idx))
            & ~((enc_a ^ $past(enc_a)) | (enc_b ^ $past(enc_b)))) == '0)
        else $error("index moved without a quadrature step");
    a_roll_no_switch:
        assert property (lim_hit[ROLL_AXIS] == 1'b0)
        else $error("roll axis reported a limit switch");
    a_fault_drv_off:
        assert property (|(lim_hit & ~$past(lim_hit)) |=> (drv_pos == '0 && drv_neg == '0) [*2])
        else $error("drive still requested after a limit hit");
    a_drive_exclusive:
        assert property ((drv_pos & drv_neg) == '0)
        else $error("both drive directions requested");
    a_reset_idx_home:
        assert property ($rose(rstn_i) |=> (enc_idx == '1 && enc_a == '0 && enc_b == '0))
        else $error("encoder not at the index slot after reset");
    a_reset_drive_off:
        assert property ($rose(rstn_i) |-> (drv_pos == '0 && drv_neg == '0) [*3])
        else $error("drive requested right after reset");

endmodule : aeh_link_monitor
`default_nettype wire

// [test/tb_axis_encoder_homing_limit.sv]
// self-checking bench: arm end and controller end joined over the link
`timescale 1ns/10ps
`default_nettype none
module tb_axis_encoder_homing_limit;
    import aeh_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [NUM_AXES-1:0] step_pins = '0, ccw_pins = '0, beam_pins = '0, jog_pos = '0, jog_neg = '0;
    logic [NUM_LIM_AXES-1:0] lim_lo = '0, lim_hi = '0;
    logic con_req = 1'b0, control_off_state_req = 1'b0, home_req = 1'b0, impact = 1'b0, thermal = 1'b0;
    logic [NUM_AXES-1:0] motor_pos, motor_neg, homed;
    logic control_on, homing, error, impact_msg, idx_d = 1'b0;
    logic [AXIS_W-1:0] home_axis;
    logic [NUM_AXES-1:0][POS_W-1:0] position;
    int mismatches = 0;
    int n_checks = 0;
    int idx_rises = 0;
    int msg_pulses = 0;

    always #20 ref_clk = ~ref_clk;

    aeh_link_if link();
    aeh_arm_end u_aeh_arm_end (.ref_clk_i(ref_clk), .rstn_i(rstn), .link(link), .shaft_step_i(step_pins),
        .shaft_ccw_i(ccw_pins), .home_beam_cut_i(beam_pins), .lim_lo_i(lim_lo), .lim_hi_i(lim_hi),
        .motor_pos_o(motor_pos), .motor_neg_o(motor_neg));
    aeh_ctl_end u_aeh_ctl_end (.ref_clk_i(ref_clk), .rstn_i(rstn), .link(link), .con_req_i(con_req),
        .control_off_state_req_i(control_off_state_req), .home_req_i(home_req), .jog_pos_i(jog_pos), .jog_neg_i(jog_neg),
        .impact_i(impact), .thermal_i(thermal), .control_on_o(control_on), .homing_o(homing),
        .home_axis_o(home_axis), .homed_o(homed), .error_o(error), .impact_msg_o(impact_msg),
        .position_o(position));
    aeh_link_monitor u_aeh_link_monitor (.ref_clk_i(ref_clk), .rstn_i(rstn), .enc_a(link.enc_a),
        .enc_b(link.enc_b), .enc_idx(link.enc_idx), .home_det(link.home_det), .lim_hit(link.lim_hit),
        .drv_pos(link.drv_pos), .drv_neg(link.drv_neg));

    // message pulses are counted per edge so a stretched pulse shows up
    always @(posedge ref_clk)
    begin
        idx_d <= link.enc_idx[0];
        if (link.enc_idx[0] === 1'b1 && idx_d === 1'b0)
            idx_rises <= idx_rises + 1;
        if (impact_msg === 1'b1)
            msg_pulses <= msg_pulses + 1;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // low time of two cycles keeps every step clear of the synchroniser
    task automatic step(input int k, input logic dir, input int n);
        repeat (n)
        begin
            ccw_pins[k] = dir;
            step_pins[k] = 1'b1;
            tick(2);
            step_pins[k] = 1'b0;
            tick(2);
        end
    endtask : step

    task automatic set_on;
        con_req = 1'b1;
        tick(1);
        con_req = 1'b0;
        tick(2);
    endtask : set_on

    task automatic lim_case(input int k, input logic hi);
        int base;
        base = msg_pulses;
        // drive toward the switch before it closes, so the fault has a drive to drop
        jog_pos[k] = hi;
        jog_neg[k] = !hi;
        tick(4);
        check(hi ? motor_pos[k] : motor_neg[k], 1'b1);
        if (hi)
            lim_hi[k] = 1'b1;
        else
            lim_lo[k] = 1'b1;
        tick(6);
        check(link.lim_hit[k], 1'b1);
        check(control_on, 1'b0);
        check(error, 1'b1);
        check(msg_pulses - base, 1);
        check(hi ? link.drv_pos[k] : link.drv_neg[k], 1'b0);
        set_on();
        check(control_on, 1'b1);
        jog_pos[k] = hi;
        jog_neg[k] = !hi;
        tick(4);
        check(hi ? link.drv_pos[k] : link.drv_neg[k], 1'b1);
        check(hi ? motor_pos[k] : motor_neg[k], 1'b0);
        jog_pos[k] = !hi;
        jog_neg[k] = hi;
        tick(4);
        check(hi ? motor_neg[k] : motor_pos[k], 1'b1);
        jog_pos[k] = 1'b0;
        jog_neg[k] = 1'b0;
        lim_hi[k] = 1'b0;
        lim_lo[k] = 1'b0;
        tick(6);
        check(control_on, 1'b1);
    endtask : lim_case

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        int n;
        int base;
        repeat (20) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        tick(3);
        check(link.enc_idx, 5'h1f);
        check(control_on, 1'b0);
        $display("test reset done");
        for (int k = 0; k < NUM_AXES; k++)
        begin
            step(k, 1'b1, 1);
            check({link.enc_a[k], link.enc_b[k]}, 2'b10);
            check(position[k], 24'h000001);
            step(k, 1'b0, 2);
            check({link.enc_a[k], link.enc_b[k]}, 2'b01);
            check(position[k], 24'hffffff);
        end
        step(0, 1'b1, 1);
        base = idx_rises;
        step(0, 1'b1, SLOTS_PER_REV * COUNTS_PER_SLOT);
        check(position[0], 24'h000800);
        check(idx_rises - base, 1);
        $display("test encoder done");
        set_on();
        check(control_on, 1'b1);
        home_req = 1'b1;
        tick(1);
        home_req = 1'b0;
        for (int k = 0; k < NUM_AXES; k++)
        begin
            n = 0;
            while (link.drv_pos[k] !== 1'b1 && n < 20)
            begin
                tick(1);
                n++;
            end
            check(link.drv_pos, 5'h01 << k);
            check(home_axis, k);
            step(k, 1'b1, 2);
            beam_pins[k] = 1'b1;
            tick(5);
            check(link.home_det[k], 1'b1);
            check(link.drv_pos[k], 1'b1);
            check(homed[k], 1'b0);
            n = 0;
            while (homed[k] !== 1'b1 && n < 2100)
            begin
                step(k, 1'b1, 1);
                n++;
            end
            check(homed[k], 1'b1);
            check(position[k], HOME_REF);
            beam_pins[k] = 1'b0;
        end
        tick(2);
        check(homing, 1'b0);
        check(homed, 5'h1f);
        $display("test homing done");
        lim_case(1, 1'b1);
        lim_case(2, 1'b0);
        $display("test limits done");
        for (int i = 0; i < 2; i++)
        begin
            base = msg_pulses;
            impact = (i == 0);
            thermal = (i == 1);
            tick(1);
            impact = 1'b0;
            thermal = 1'b0;
            tick(3);
            check(control_on, 1'b0);
            check(error, 1'b1);
            check(msg_pulses - base, 1);
            set_on();
            check(error, 1'b0);
        end
        control_off_state_req = 1'b1;
        tick(1);
        control_off_state_req = 1'b0;
        tick(2);
        check(control_on, 1'b0);
        $display("test protection done");
        complete_run();
    end

    // the whole sequence takes near 50000 cycles
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        complete_run();
    end

endmodule : tb_axis_encoder_homing_limit
`default_nettype wire
